/* core/ifd_decoder.v */
// instruction format decoder top, registered outputs
`timescale 1ns/1ps
`include "ifd_regs.vh"
module ifd_decoder (
	CLK_SYS,
	RESETN,
	INSTR_VALID,
	INSTR_BITS,
	OPCODE_CLASS,
	NEXT_LOC,
	COND_CODE,
	IS_COND_BRANCH,
	INDEX_A_VAL,
	INDEX_B_VAL,
	PAIR_INDEX_A_VAL,
	PAIR_INDEX_B_VAL,
	DEC_VALID,
	FORMAT,
	OPCODE_FIELD,
	FIRST_OPERAND_REGISTER,
	SECOND_OPERAND_REGISTER,
	SECOND_IS_IMMEDIATE,
	SECOND_OPERAND_VALUE,
	INDEX_REGISTER_FIELD,
	SECOND_INDEX_FIELD,
	SECOND_ADDRESS,
	BRANCH_TAKEN,
	OPERATION_MODIFIER_FIELD,
	FIRST_LENGTH_FIELD,
	FIRST_LENGTH_LITERAL,
	SECOND_LENGTH_FIELD,
	SECOND_LENGTH_LITERAL,
	FIRST_MEMBER_ADDRESS,
	SECOND_MEMBER_ADDRESS,
	LENGTH_HALFWORDS
);
	input  wire        CLK_SYS;
	input  wire        RESETN;
	input  wire        INSTR_VALID;
	input  wire [95:0] INSTR_BITS;
	input  wire [2:0]  OPCODE_CLASS;
	input  wire [31:0] NEXT_LOC;
	input  wire [3:0]  COND_CODE;
	input  wire        IS_COND_BRANCH;
	input  wire [31:0] INDEX_A_VAL;
	input  wire [31:0] INDEX_B_VAL;
	input  wire [31:0] PAIR_INDEX_A_VAL;
	input  wire [31:0] PAIR_INDEX_B_VAL;
	output reg         DEC_VALID;
	output reg  [2:0]  FORMAT;
	output reg  [7:0]  OPCODE_FIELD;
	output reg  [3:0]  FIRST_OPERAND_REGISTER;
	output reg  [3:0]  SECOND_OPERAND_REGISTER;
	output reg         SECOND_IS_IMMEDIATE;
	output reg  [31:0] SECOND_OPERAND_VALUE;
	output reg  [3:0]  INDEX_REGISTER_FIELD;
	output reg  [3:0]  SECOND_INDEX_FIELD;
	output reg  [31:0] SECOND_ADDRESS;
	output reg         BRANCH_TAKEN;
	output reg  [7:0]  OPERATION_MODIFIER_FIELD;
	output reg  [3:0]  FIRST_LENGTH_FIELD;
	output reg         FIRST_LENGTH_LITERAL;
	output reg  [3:0]  SECOND_LENGTH_FIELD;
	output reg         SECOND_LENGTH_LITERAL;
	output reg  [31:0] FIRST_MEMBER_ADDRESS;
	output reg  [31:0] SECOND_MEMBER_ADDRESS;
	output reg  [3:0]  LENGTH_HALFWORDS;

	reg         rst_meta_ff;
	reg         rst_sync_ff;
	wire        rst_n;
	wire [7:0]  opcode_field;
	wire [3:0]  first_operand_register;
	wire [3:0]  second_operand_register;
	wire [2:0]  m1_fmt;
	wire [2:0]  m1_hw;
	wire [3:0]  m1_fx;
	wire [3:0]  m1_sx;
	wire [31:0] m1_addr;
	wire [2:0]  m2_fmt;
	wire [2:0]  m2_hw;
	wire [31:0] m2_addr;
	wire [47:0] member2_bits;
	wire [31:0] m2_loc;
	wire [31:0] idx_a;
	wire [31:0] wide_immediate_field;
	reg  [2:0]  nxt_format;
	reg         nxt_sec_imm;
	reg  [31:0] nxt_sec_val;
	reg  [31:0] nxt_sec_addr;
	reg  [3:0]  nxt_len;
	reg  [3:0]  nxt_sec_idx;
	reg  [7:0]  nxt_mod;

	// reset release through two flops, assert stays asynchronous
	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	assign opcode_field            = INSTR_BITS[95:88];
	assign first_operand_register  = INSTR_BITS[87:84];
	assign second_operand_register = INSTR_BITS[83:80];
	assign idx_a = (second_operand_register == 4'h0) ? 32'h0 : INDEX_A_VAL;
	assign wide_immediate_field = INSTR_BITS[79:48];

	ifd_member u_member1 (
		.member_bits        (INSTR_BITS[95:48]),
		.index_a_val        (INDEX_A_VAL),
		.index_b_val        (INDEX_B_VAL),
		.next_loc           (NEXT_LOC),
		.fmt                (m1_fmt),
		.halfwords          (m1_hw),
		.first_index_field  (m1_fx),
		.second_index_field (m1_sx),
		.address            (m1_addr)
	);

	// second member starts after first, modifier between
	assign member2_bits = (m1_hw == `IFD_LEN_RX3) ? INSTR_BITS[47:0] :
		{INSTR_BITS[63:16]};
	// second member closes the instruction, so its counter is the instruction's
	assign m2_loc = NEXT_LOC;

	ifd_member u_member2 (
		.member_bits        ({member2_bits[47:40] & 8'h00, member2_bits[39:0]}),
		.index_a_val        (PAIR_INDEX_A_VAL),
		.index_b_val        (PAIR_INDEX_B_VAL),
		.next_loc           (m2_loc),
		.fmt                (m2_fmt),
		.halfwords          (m2_hw),
		.first_index_field  (),
		.second_index_field (),
		.address            (m2_addr)
	);

	always @* begin
		nxt_format = `IFD_FMT_RR;
		nxt_sec_imm = 1'b0;
		nxt_sec_val = 32'h0;
		nxt_sec_addr = 32'h0;
		nxt_len = {1'b0, `IFD_LEN_RR};
		nxt_sec_idx = 4'h0;
		nxt_mod = 8'h0;
		// branch opcodes share these format paths
		case (OPCODE_CLASS)
		`IFD_CLS_RR: begin
			nxt_format = `IFD_FMT_RR;
		end
		`IFD_CLS_SF: begin
			nxt_format = `IFD_FMT_SF;
			nxt_sec_imm = 1'b1;
			nxt_sec_val = {28'h0, second_operand_register};
		end
		`IFD_CLS_RX: begin
			nxt_format = m1_fmt;
			nxt_sec_addr = m1_addr;
			nxt_sec_idx = m1_sx;
			nxt_len = {1'b0, m1_hw};
		end
		`IFD_CLS_RI1: begin
			nxt_format = `IFD_FMT_RI1;
			nxt_sec_imm = 1'b1;
			nxt_sec_val = {{16{INSTR_BITS[79]}}, INSTR_BITS[79:64]} + idx_a;
			nxt_len = {1'b0, `IFD_LEN_RX1};
		end
		`IFD_CLS_RI2: begin
			nxt_format = `IFD_FMT_RI2;
			nxt_sec_imm = 1'b1;
			nxt_sec_val = wide_immediate_field + idx_a;
			nxt_len = {1'b0, `IFD_LEN_RI2};
		end
		`IFD_CLS_PAIR: begin
			nxt_format = `IFD_FMT_PAIR;
			nxt_sec_addr = m2_addr;
			nxt_mod = (m1_hw == `IFD_LEN_RX3) ? INSTR_BITS[47:40] : INSTR_BITS[63:56];
			nxt_len = {1'b0, m1_hw} + {1'b0, m2_hw};
		end
		default: begin
			nxt_format = `IFD_FMT_RR;
		end
		endcase
	end

	always @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			DEC_VALID <= 1'b0;
			FORMAT <= `IFD_FMT_RR;
			OPCODE_FIELD <= 8'h00;
			FIRST_OPERAND_REGISTER <= 4'h0;
			SECOND_OPERAND_REGISTER <= 4'h0;
			SECOND_IS_IMMEDIATE <= 1'b0;
			SECOND_OPERAND_VALUE <= 32'h0;
			INDEX_REGISTER_FIELD <= 4'h0;
			SECOND_INDEX_FIELD <= 4'h0;
			SECOND_ADDRESS <= 32'h0;
			BRANCH_TAKEN <= 1'b0;
			OPERATION_MODIFIER_FIELD <= 8'h00;
			FIRST_LENGTH_FIELD <= 4'h0;
			FIRST_LENGTH_LITERAL <= 1'b0;
			SECOND_LENGTH_FIELD <= 4'h0;
			SECOND_LENGTH_LITERAL <= 1'b0;
			FIRST_MEMBER_ADDRESS <= 32'h0;
			SECOND_MEMBER_ADDRESS <= 32'h0;
			LENGTH_HALFWORDS <= 4'h0;
		end else begin
			DEC_VALID <= INSTR_VALID;
			if (INSTR_VALID) begin
				FORMAT <= nxt_format;
				OPCODE_FIELD <= opcode_field;
				FIRST_OPERAND_REGISTER <= first_operand_register;
				SECOND_OPERAND_REGISTER <= second_operand_register;
				SECOND_IS_IMMEDIATE <= nxt_sec_imm;
				SECOND_OPERAND_VALUE <= nxt_sec_val;
				INDEX_REGISTER_FIELD <= m1_fx;
				SECOND_INDEX_FIELD <= nxt_sec_idx;
				SECOND_ADDRESS <= nxt_sec_addr;
				BRANCH_TAKEN <= IS_COND_BRANCH & (|(first_operand_register & COND_CODE));
				OPERATION_MODIFIER_FIELD <= nxt_mod;
				FIRST_LENGTH_FIELD <= first_operand_register;
				FIRST_LENGTH_LITERAL <= nxt_mod[7];
				// second length sits after the modifier byte
				SECOND_LENGTH_FIELD <= member2_bits[39:36];
				SECOND_LENGTH_LITERAL <= nxt_mod[6];
				FIRST_MEMBER_ADDRESS <= m1_addr;
				SECOND_MEMBER_ADDRESS <= m2_addr;
				LENGTH_HALFWORDS <= nxt_len;
			end
		end
	end
endmodule

/* core/ifd_member.v */
// one indexed storage member: format detect and address forming
`timescale 1ns/1ps
`include "ifd_regs.vh"
module ifd_member (
	member_bits,
	index_a_val,
	index_b_val,
	next_loc,
	fmt,
	halfwords,
	first_index_field,
	second_index_field,
	address
);
	input  wire [47:0] member_bits;
	input  wire [31:0] index_a_val;
	input  wire [31:0] index_b_val;
	input  wire [31:0] next_loc;
	output reg  [2:0]  fmt;
	output reg  [2:0]  halfwords;
	output wire [3:0]  first_index_field;
	output wire [3:0]  second_index_field;
	output reg  [31:0] address;

	wire [31:0] idx_a;
	wire [31:0] idx_b;
	wire [31:0] rel_disp;

	assign first_index_field  = member_bits[35:32];
	assign second_index_field = member_bits[27:24];
	assign idx_a = (first_index_field == 4'h0) ? 32'h0 : index_a_val;
	assign idx_b = (second_index_field == 4'h0) ? 32'h0 : index_b_val;
	assign rel_disp = {{17{member_bits[30]}}, member_bits[30:16]};

	always @* begin
		fmt = `IFD_FMT_RX1;
		halfwords = `IFD_LEN_RX1;
		address = 32'h0;
		if (member_bits[31]) begin
			fmt = `IFD_FMT_RX2;
			address = next_loc + rel_disp + idx_a;
		end else if (member_bits[31:28] == `IFD_RX3_TAG) begin
			fmt = `IFD_FMT_RX3;
			halfwords = `IFD_LEN_RX3;
			address = idx_a + idx_b + {8'h0, member_bits[23:0]};
		end else begin
			address = idx_a + {18'h0, member_bits[29:16]};
		end
	end
endmodule

/* core/ifd_regs.vh */
// constants for the instruction format decoder
`ifndef IFD_REGS_VH
`define IFD_REGS_VH
`define IFD_FMT_RR      3'h0
`define IFD_FMT_SF      3'h1
`define IFD_FMT_RX1     3'h2
`define IFD_FMT_RX2     3'h3
`define IFD_FMT_RX3     3'h4
`define IFD_FMT_RI1     3'h5
`define IFD_FMT_RI2     3'h6
`define IFD_FMT_PAIR    3'h7
`define IFD_CLS_RR      3'h0
`define IFD_CLS_SF      3'h1
`define IFD_CLS_RX      3'h2
`define IFD_CLS_RI1     3'h3
`define IFD_CLS_RI2     3'h4
`define IFD_CLS_PAIR    3'h5
`define IFD_RX3_TAG     4'h4
`define IFD_LEN_RR      3'h1
`define IFD_LEN_RX1     3'h2
`define IFD_LEN_RX3     3'h3
`define IFD_LEN_RI2     3'h3
`endif

/* testbench/ifd_decoder_monitor.sv */
// assertion checker for the instruction format decoder ports
`timescale 1ns/1ps
module ifd_decoder_monitor (
	input wire        CLK_SYS,
	input wire        RESETN,
	input wire        INSTR_VALID,
	input wire [95:0] INSTR_BITS,
	input wire [2:0]  OPCODE_CLASS,
	input wire [31:0] NEXT_LOC,
	input wire [3:0]  COND_CODE,
	input wire        IS_COND_BRANCH,
	input wire [31:0] INDEX_A_VAL,
	input wire        DEC_VALID,
	input wire [2:0]  FORMAT,
	input wire [7:0]  OPCODE_FIELD,
	input wire [3:0]  FIRST_OPERAND_REGISTER,
	input wire [3:0]  SECOND_OPERAND_REGISTER,
	input wire        SECOND_IS_IMMEDIATE,
	input wire [31:0] SECOND_OPERAND_VALUE,
	input wire [31:0] SECOND_ADDRESS,
	input wire        BRANCH_TAKEN,
	input wire [3:0]  LENGTH_HALFWORDS
);
	default clocking dc @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	// index field zero means no index at all
	wire        nx = INSTR_BITS[83:80] == 4'h0;
	wire [31:0] ia = nx ? 32'h0 : INDEX_A_VAL;
	wire        rx = INSTR_VALID && OPCODE_CLASS == 3'h2;
	wire        r1 = rx && INSTR_BITS[79:78] == 2'b00;
	wire [31:0] da = {18'h0, INSTR_BITS[77:64]};
	wire [31:0] ra = NEXT_LOC + {{17{INSTR_BITS[78]}}, INSTR_BITS[78:64]} + ia;
	AST_OPCODE: assert property (INSTR_VALID |=> DEC_VALID && OPCODE_FIELD == $past(INSTR_BITS[95:88]))
		else $error("opcode or strobe wrong");
	AST_HOLD: assert property (!INSTR_VALID |=> !DEC_VALID && $stable(SECOND_ADDRESS))
		else $error("outputs moved while idle");
	AST_FIRST_REG: assert property (INSTR_VALID |=> FIRST_OPERAND_REGISTER == $past(INSTR_BITS[87:84]))
		else $error("first register field wrong");
	AST_RR: assert property (INSTR_VALID && OPCODE_CLASS == 3'h0 |=> FORMAT == 3'h0 &&
		SECOND_OPERAND_REGISTER == $past(INSTR_BITS[83:80]) && LENGTH_HALFWORDS == 4'h1)
		else $error("register pair decode wrong");
	AST_SF: assert property (INSTR_VALID && OPCODE_CLASS == 3'h1 |=> FORMAT == 3'h1 &&
		SECOND_IS_IMMEDIATE && SECOND_OPERAND_VALUE == {28'h0, $past(INSTR_BITS[83:80])})
		else $error("short immediate wrong");
	AST_RX1: assert property (r1 && !nx |=> FORMAT == 3'h2 && SECOND_ADDRESS == $past(INDEX_A_VAL + da))
		else $error("indexed address wrong");
	AST_NO_INDEX: assert property (r1 && nx |=> SECOND_ADDRESS == $past(da))
		else $error("unindexed address wrong");
	AST_RX2: assert property (rx && INSTR_BITS[79] |=> FORMAT == 3'h3 && SECOND_ADDRESS == $past(ra))
		else $error("relative address wrong");
	AST_RI2: assert property (INSTR_VALID && OPCODE_CLASS == 3'h4 |=> LENGTH_HALFWORDS == 4'h3 &&
		SECOND_OPERAND_VALUE == $past(ia + INSTR_BITS[79:48]))
		else $error("wide immediate wrong");
	AST_BRANCH: assert property (INSTR_VALID |=>
		BRANCH_TAKEN == $past(IS_COND_BRANCH && (INSTR_BITS[87:84] & COND_CODE) != 4'h0))
		else $error("branch decision wrong");
	cover property (DEC_VALID && BRANCH_TAKEN);
	cover property (DEC_VALID ##1 DEC_VALID);
	cover property (r1 && nx);
endmodule
bind ifd_decoder ifd_decoder_monitor ifd_decoder_monitor_i (.*);

/* testbench/tb_ifd_decoder.sv */
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
module tb_ifd_decoder;
	typedef struct {logic [2:0] f; logic [7:0] op; logic [3:0] r; logic [31:0] v;
		logic [3:0] n; logic b; logic i; logic [3:0] x; logic [3:0] s; logic [7:0] o;
		logic [31:0] w;} exp_t;
	localparam logic [2:0] fm[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5, 3'h7};
	localparam logic [2:0] cl[8] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h4, 3'h2, 3'h3, 3'h5};
	localparam logic [3:0] ln[8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h2, 4'h4};
	logic        CLK_SYS = 0;
	logic        RESETN = 0;
	logic        INSTR_VALID = 0;
	logic [95:0] INSTR_BITS = '0;
	logic [2:0]  OPCODE_CLASS = '0;
	logic [31:0] NEXT_LOC = '0;
	logic [31:0] INDEX_A_VAL = '0;
	logic [31:0] INDEX_B_VAL = '0;
	logic [31:0] PAIR_INDEX_A_VAL = '0;
	logic [31:0] PAIR_INDEX_B_VAL = '0;
	logic [3:0]  COND_CODE = '0;
	logic        IS_COND_BRANCH = 0;
	wire         DEC_VALID, BRANCH_TAKEN;
	wire  [2:0]  FORMAT;
	wire  [7:0]  OPCODE_FIELD;
	wire  [3:0]  FIRST_OPERAND_REGISTER, SECOND_OPERAND_REGISTER, LENGTH_HALFWORDS;
	wire  [31:0] SECOND_OPERAND_VALUE, SECOND_ADDRESS;
	wire         SECOND_IS_IMMEDIATE, FIRST_LENGTH_LITERAL, SECOND_LENGTH_LITERAL;
	wire  [3:0]  INDEX_REGISTER_FIELD, SECOND_INDEX_FIELD;
	wire  [3:0]  FIRST_LENGTH_FIELD, SECOND_LENGTH_FIELD;
	wire  [7:0]  OPERATION_MODIFIER_FIELD;
	wire  [31:0] FIRST_MEMBER_ADDRESS, SECOND_MEMBER_ADDRESS;
	exp_t        q[$];
	exp_t        m;
	int          fail_count = 0;
	int          samples_checked = 0;
	logic [31:0] rs = 32'h0a657582;
	ifd_decoder ifd_decoder_i (.CLK_SYS, .RESETN, .INSTR_VALID, .INSTR_BITS, .OPCODE_CLASS,
		.NEXT_LOC, .COND_CODE, .IS_COND_BRANCH, .INDEX_A_VAL, .INDEX_B_VAL,
		.PAIR_INDEX_A_VAL, .PAIR_INDEX_B_VAL, .DEC_VALID, .FORMAT,
		.OPCODE_FIELD, .FIRST_OPERAND_REGISTER, .SECOND_OPERAND_REGISTER,
		.SECOND_IS_IMMEDIATE, .SECOND_OPERAND_VALUE, .INDEX_REGISTER_FIELD,
		.SECOND_INDEX_FIELD, .SECOND_ADDRESS, .BRANCH_TAKEN, .OPERATION_MODIFIER_FIELD,
		.FIRST_LENGTH_FIELD, .FIRST_LENGTH_LITERAL, .SECOND_LENGTH_FIELD,
		.SECOND_LENGTH_LITERAL, .FIRST_MEMBER_ADDRESS, .SECOND_MEMBER_ADDRESS,
		.LENGTH_HALFWORDS);
	always #4 CLK_SYS = ~CLK_SYS;
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (e !== g) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// a holds doc bits 0..31 msb first
	task automatic send(int k);
		logic [31:0] a, b, x, v, w;
		a = rnd();
		b = rnd();
		if (b[0]) a[19:16] = 4'h0;
		if (b[1]) a[11:8] = 4'h0;
		if (k == 2 || k == 7) a[15:14] = 2'b00;
		if (k == 3) a[15] = 1'b1;
		if (k == 5) a[15:12] = 4'h4;
		// pair: second member kept absolute indexed
		if (k == 7) b[15:14] = 2'b00;
		if (k == 7 && b[2]) b[19:16] = 4'h0;
		INDEX_A_VAL = rnd();
		INDEX_B_VAL = rnd();
		PAIR_INDEX_A_VAL = rnd();
		PAIR_INDEX_B_VAL = rnd();
		NEXT_LOC = rnd();
		{COND_CODE, IS_COND_BRANCH} = b[8:4];
		x = (a[19:16] == 4'h0) ? 32'h0 : INDEX_A_VAL;
		w = x + {18'h0, a[13:0]};
		case (k)
			2: v = w;
			3: v = NEXT_LOC + {{17{a[14]}}, a[14:0]} + x;
			4: v = x + {a[15:0], b[31:16]};
			5: v = x + ((a[11:8] == 4'h0) ? 32'h0 : INDEX_B_VAL) + {8'h0, a[7:0], b[31:16]};
			6: v = x + {{16{a[15]}}, a[15:0]};
			7: v = ((b[19:16] == 4'h0) ? 32'h0 : PAIR_INDEX_A_VAL) + {18'h0, b[13:0]};
			default: v = {28'h0, a[19:16]};
		endcase
		if (k != 7) w = v;
		INSTR_BITS = {a, b, rnd()};
		OPCODE_CLASS = cl[k];
		INSTR_VALID = 1;
		q.push_back('{fm[k], a[31:24], a[23:20], v, ln[k], b[4] & |(a[23:20] & b[8:5]),
			k == 1 || k == 4 || k == 6, a[19:16], (k == 7) ? b[23:20] : a[11:8],
			b[31:24], w});
		@(posedge CLK_SYS);
		#1;
	endtask
	// sample mid-cycle, well clear of the launching edge
	always @(negedge CLK_SYS) begin
		if (DEC_VALID === 1'b1) begin
			if (q.size() == 0) chk("queue", 0, 1);
			m = q.pop_front();
			chk("format", m.f, FORMAT);
			chk("opcode", m.op, OPCODE_FIELD);
			chk("first", m.r, FIRST_OPERAND_REGISTER);
			chk("length", m.n, LENGTH_HALFWORDS);
			chk("branch", m.b, BRANCH_TAKEN);
			chk("immediate", m.i, SECOND_IS_IMMEDIATE);
			chk("index", m.x, INDEX_REGISTER_FIELD);
			if (m.f == 3'h0) chk("second reg", m.v, SECOND_OPERAND_REGISTER);
			else if (m.f == 3'h1 || m.f == 3'h5 || m.f == 3'h6) begin
				chk("operand", m.v, SECOND_OPERAND_VALUE);
			end else begin
				chk("address", m.v, SECOND_ADDRESS);
				chk("member one", m.w, FIRST_MEMBER_ADDRESS);
			end
			if (m.f == 3'h4) chk("second index", m.s, SECOND_INDEX_FIELD);
			if (m.f == 3'h7) begin
				chk("modifier", m.o, OPERATION_MODIFIER_FIELD);
				chk("first length", m.r, FIRST_LENGTH_FIELD);
				chk("first literal", m.o[7], FIRST_LENGTH_LITERAL);
				chk("second length", m.s, SECOND_LENGTH_FIELD);
				chk("second literal", m.o[6], SECOND_LENGTH_LITERAL);
				chk("member two", m.v, SECOND_MEMBER_ADDRESS);
			end
		end
	end
	initial begin
		repeat (4) @(posedge CLK_SYS);
		#1 RESETN = 1;
		repeat (4) @(posedge CLK_SYS);
		#1;
		for (int i = 0; i < 500; i++) begin
			send(i % 8);
			if (rs[3]) begin
				INSTR_VALID = 0;
				INSTR_BITS = {rnd(), rnd(), rnd()};
				@(posedge CLK_SYS);
				#1;
			end
		end
		INSTR_VALID = 0;
		repeat (3) @(posedge CLK_SYS);
		chk("pending", 0, q.size());
		conclude();
	end
endmodule
